// [hdl/parallel_port_pkg.sv]
// Constants and types shared by the dual parallel port adapter
package parallel_port_pkg;

  // ----------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_PORT_B = 4'h0;
  localparam logic [3:0] REG_PORT_A = 4'h1;
  localparam logic [3:0] REG_DIR_B = 4'h2;
  localparam logic [3:0] REG_DIR_A = 4'h3;
  localparam logic [3:0] REG_AUX_CTRL = 4'hB;
  localparam logic [3:0] REG_PERIPH_CTRL = 4'hC;
  localparam logic [3:0] REG_IRQ_FLAGS = 4'hD;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'hE;
  localparam logic [3:0] REG_PORT_A_QUIET = 4'hF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] RESET_FLAGS = 7'h00;

  // ----------------------------------------------------------------
  // Auxiliary control fields
  // ----------------------------------------------------------------
  localparam int AUX_LATCH_A = 0;
  localparam int AUX_LATCH_B = 1;

  // ----------------------------------------------------------------
  // Peripheral control fields
  // ----------------------------------------------------------------
  localparam int PC_A_IN_EDGE = 0;
  localparam int PC_A_IO_LSB = 1;
  localparam int PC_B_IN_EDGE = 4;
  localparam int PC_B_IO_LSB = 5;

  // ----------------------------------------------------------------
  // Interrupt flag and enable positions
  // ----------------------------------------------------------------
  localparam int FLAG_A_IO = 0;
  localparam int FLAG_A_IN = 1;
  localparam int FLAG_B_IO = 3;
  localparam int FLAG_B_IN = 4;
  localparam int IER_SET_BIT = 7;

  // ----------------------------------------------------------------
  // Capture buffer
  // ----------------------------------------------------------------
  localparam int CAPTURE_DEPTH = 8;

  // Bit 0 selects the edge in the input modes
  typedef enum logic [2:0] {
    CTL_IN_FALL = 3'b000,
    CTL_IN_RISE = 3'b001,
    CTL_HANDSHAKE = 3'b100,
    CTL_PULSE = 3'b101,
    CTL_MANUAL_LOW = 3'b110,
    CTL_MANUAL_HIGH = 3'b111
  } ctl_mode_t;

endpackage

// [hdl/capture_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
module capture_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Depth must be a power of two for the wrap bit to work
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) &&
                      (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule // capture_fifo

// [hdl/dual_parallel_port.sv]
// Processor bus interface and two handshaking 8-bit parallel ports
module dual_parallel_port
  import parallel_port_pkg::*;
#(
  parameter int CAPTURE_WORDS = parallel_port_pkg::CAPTURE_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic phase_two,
  input wire logic select_high_input,
  input wire logic select_low_input_n,
  input wire logic read_not_write,
  input wire logic reg_sel_bit0,
  input wire logic reg_sel_bit1,
  input wire logic reg_sel_bit2,
  input wire logic reg_sel_bit3,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe,
  output logic irq_n_out,
  output logic irq_n_oe,
  input wire logic [7:0] port_a_pins_in,
  output logic [7:0] port_a_pins_out,
  output logic [7:0] port_a_pins_oe,
  input wire logic [7:0] port_b_pins_in,
  output logic [7:0] port_b_pins_out,
  output logic [7:0] port_b_pins_oe,
  input wire logic ctrl_a_in,
  input wire logic ctrl_a_io_in,
  output logic ctrl_a_io_out,
  output logic ctrl_a_io_oe,
  input wire logic ctrl_b_in,
  input wire logic ctrl_b_io_in,
  output logic ctrl_b_io_out,
  output logic ctrl_b_io_oe,
  output logic port_a_capture_ready,
  input wire logic timer_output_enable,
  input wire logic timer_output_level,
  output logic pulse_count_strobe,
  input wire logic serial_owns_ctrl_b,
  input wire logic serial_data_drive,
  input wire logic serial_data_out,
  output logic serial_clock_in,
  output logic serial_data_in
);

  import parallel_port_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rising);
    edge_hit = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  function automatic logic mode_drives(input logic [2:0] mode);
    mode_drives = mode[2];
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] port_a_output_value;
  logic [7:0] port_b_output_value;
  logic [7:0] port_a_direction;
  logic [7:0] port_b_direction;
  logic [7:0] aux_ctrl;
  logic [7:0] periph_ctrl;
  logic [6:0] irq_flags;
  logic [6:0] irq_enable;
  logic [7:0] hold_data;
  logic [3:0] hold_addr;
  logic hold_write;
  logic hold_valid;
  logic phase_two_q;
  logic ctrl_a_in_q;
  logic ctrl_b_in_q;
  logic ctrl_a_io_q;
  logic ctrl_b_io_q;
  logic pulse_pin_q;
  logic ctrl_a_level;
  logic ctrl_b_level;
  logic [7:0] port_b_frozen;

  // ----------------------------------------------------------------
  // Chip access decode
  // ----------------------------------------------------------------
  wire [3:0] reg_sel = {reg_sel_bit3, reg_sel_bit2, reg_sel_bit1,
                        reg_sel_bit0};
  wire chip_sel = select_high_input && !select_low_input_n;
  wire access_now = chip_sel && phase_two;
  // Commit at the falling phase-two edge so pins change cleanly
  wire phase_two_fall = phase_two_q && !phase_two;
  wire commit = hold_valid && phase_two_fall;
  wire commit_wr = commit && hold_write;
  wire commit_rd = commit && !hold_write;
  wire [7:0] next_data = hold_data;

  wire hit_port_b = (hold_addr == REG_PORT_B);
  wire hit_port_a = (hold_addr == REG_PORT_A);
  wire hit_port_a_quiet = (hold_addr == REG_PORT_A_QUIET);
  wire hit_dir_b = (hold_addr == REG_DIR_B);
  wire hit_dir_a = (hold_addr == REG_DIR_A);
  wire hit_aux = (hold_addr == REG_AUX_CTRL);
  wire hit_periph = (hold_addr == REG_PERIPH_CTRL);
  wire hit_flags = (hold_addr == REG_IRQ_FLAGS);
  wire hit_enable = (hold_addr == REG_IRQ_ENABLE);

  wire port_a_access = commit && (hit_port_a || hit_port_a_quiet);
  wire port_a_shake = commit && hit_port_a;
  wire port_b_access = commit && hit_port_b;
  wire port_b_shake = commit_wr && hit_port_b;

  // ----------------------------------------------------------------
  // Mode fields
  // ----------------------------------------------------------------
  wire latch_a = aux_ctrl[AUX_LATCH_A];
  wire latch_b = aux_ctrl[AUX_LATCH_B];
  wire a_in_rise = periph_ctrl[PC_A_IN_EDGE];
  wire b_in_rise = periph_ctrl[PC_B_IN_EDGE];
  wire [2:0] a_io_mode = periph_ctrl[PC_A_IO_LSB +: 3];
  wire [2:0] b_io_mode = periph_ctrl[PC_B_IO_LSB +: 3];

  // ----------------------------------------------------------------
  // Control line edges
  // ----------------------------------------------------------------
  wire a_in_edge = edge_hit(ctrl_a_in_q, ctrl_a_in, a_in_rise);
  wire a_io_edge = !mode_drives(a_io_mode) &&
                   edge_hit(ctrl_a_io_q, ctrl_a_io_in, a_io_mode[0]);
  // Shifter takes both port B control lines when it runs
  wire b_in_edge = !serial_owns_ctrl_b &&
                   edge_hit(ctrl_b_in_q, ctrl_b_in, b_in_rise);
  wire b_io_edge = !serial_owns_ctrl_b && !mode_drives(b_io_mode) &&
                   edge_hit(ctrl_b_io_q, ctrl_b_io_in, b_io_mode[0]);

  // ----------------------------------------------------------------
  // Port A capture buffer
  // ----------------------------------------------------------------
  wire capture_valid;
  wire [7:0] capture_data;
  wire capture_push = latch_a && a_in_edge;
  wire capture_pop = latch_a && commit_rd && hit_port_a;

  capture_fifo #(
    .WIDTH(8),
    .DEPTH(CAPTURE_WORDS)
  ) u_capture (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(capture_push),
    .in_ready(port_a_capture_ready),
    .in_data(port_a_pins_in),
    .out_valid(capture_valid),
    .out_ready(capture_pop),
    .out_data(capture_data)
  );

  // ----------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------
  // Unlatched reads see the live pins; port B output bits read the output register
  wire [7:0] port_a_input_value = latch_a ? capture_data
                                          : port_a_pins_in;
  wire [7:0] port_b_live = (port_b_pins_in & ~port_b_direction) |
                           (port_b_output_value & port_b_direction);
  wire port_b_hold = latch_b && irq_flags[FLAG_B_IN];
  wire [7:0] port_b_input_value = port_b_hold ? port_b_frozen
                                              : port_b_live;

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  always_comb begin
    flag_set = '0;
    flag_set[FLAG_A_IN] = a_in_edge;
    flag_set[FLAG_A_IO] = a_io_edge;
    flag_set[FLAG_B_IN] = b_in_edge;
    flag_set[FLAG_B_IO] = b_io_edge;
    flag_clr = (commit_wr && hit_flags) ? next_data[6:0] : 7'h00;
    if (port_a_access) begin
      flag_clr[FLAG_A_IN] = 1'b1;
      flag_clr[FLAG_A_IO] = 1'b1;
    end
    if (port_b_access) begin
      flag_clr[FLAG_B_IN] = 1'b1;
      flag_clr[FLAG_B_IO] = 1'b1;
    end
  end
  // A new event beats a clear in the same cycle
  wire [6:0] next_flags = (irq_flags & ~flag_clr) | flag_set;
  wire irq_active = |(irq_flags & irq_enable);

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  logic [7:0] read_mux;
  always_comb begin
    case (reg_sel)
      REG_PORT_B: read_mux = port_b_input_value;
      REG_PORT_A: read_mux = port_a_input_value;
      REG_PORT_A_QUIET: read_mux = port_a_input_value;
      REG_DIR_B: read_mux = port_b_direction;
      REG_DIR_A: read_mux = port_a_direction;
      REG_AUX_CTRL: read_mux = aux_ctrl;
      REG_PERIPH_CTRL: read_mux = periph_ctrl;
      REG_IRQ_FLAGS: read_mux = {irq_active, irq_flags};
      REG_IRQ_ENABLE: read_mux = {1'b1, irq_enable};
      default: read_mux = RESET_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus side: holding register and read drive
  // ----------------------------------------------------------------
  assign host_data_bus_oe = access_now && read_not_write;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_data_bus_out <= RESET_BYTE;
      phase_two_q <= 1'b0;
    end else begin
      host_data_bus_out <= read_mux;
      phase_two_q <= phase_two;
    end
  end

  // Address and data are sampled through the whole high phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_data <= RESET_BYTE;
      hold_addr <= 4'h0;
      hold_write <= 1'b0;
      hold_valid <= 1'b0;
    end else if (access_now) begin
      hold_data <= host_data_bus_in;
      hold_addr <= reg_sel;
      hold_write <= !read_not_write;
      hold_valid <= 1'b1;
    end else if (!phase_two) begin
      hold_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_output_value <= RESET_BYTE;
      port_b_output_value <= RESET_BYTE;
      port_a_direction <= RESET_BYTE;
      port_b_direction <= RESET_BYTE;
      aux_ctrl <= RESET_BYTE;
      periph_ctrl <= RESET_BYTE;
    end else if (commit_wr) begin
      if (hit_port_a || hit_port_a_quiet) begin
        port_a_output_value <= next_data;
      end
      if (hit_port_b) begin
        port_b_output_value <= next_data;
      end
      if (hit_dir_a) begin
        port_a_direction <= next_data;
      end
      if (hit_dir_b) begin
        port_b_direction <= next_data;
      end
      if (hit_aux) begin
        aux_ctrl <= next_data;
      end
      if (hit_periph) begin
        periph_ctrl <= next_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_flags <= RESET_FLAGS;
      irq_enable <= RESET_FLAGS;
    end else begin
      irq_flags <= next_flags;
      if (commit_wr && hit_enable) begin
        irq_enable <= next_data[IER_SET_BIT] ?
                      (irq_enable | next_data[6:0]) :
                      (irq_enable & ~next_data[6:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Edge history and port B freeze
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_in_q <= 1'b0;
      ctrl_b_in_q <= 1'b0;
      ctrl_a_io_q <= 1'b0;
      ctrl_b_io_q <= 1'b0;
      pulse_pin_q <= 1'b0;
      port_b_frozen <= RESET_BYTE;
    end else begin
      ctrl_a_in_q <= ctrl_a_in;
      ctrl_b_in_q <= ctrl_b_in;
      ctrl_a_io_q <= ctrl_a_io_in;
      ctrl_b_io_q <= ctrl_b_io_in;
      pulse_pin_q <= port_b_pins_in[6];
      if (!port_b_hold) begin
        port_b_frozen <= port_b_live;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs: handshake, pulse and manual levels
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_level <= 1'b1;
      ctrl_b_level <= 1'b1;
    end else begin
      case (a_io_mode)
        CTL_HANDSHAKE: begin
          if (port_a_shake) begin
            ctrl_a_level <= 1'b0;
          end else if (a_in_edge) begin
            ctrl_a_level <= 1'b1;
          end
        end
        CTL_PULSE: begin
          if (port_a_shake) begin
            ctrl_a_level <= 1'b0;
          end else if (phase_two_fall) begin
            ctrl_a_level <= 1'b1;
          end
        end
        CTL_MANUAL_LOW: ctrl_a_level <= 1'b0;
        CTL_MANUAL_HIGH: ctrl_a_level <= 1'b1;
        default: ctrl_a_level <= 1'b1;
      endcase
      case (b_io_mode)
        CTL_HANDSHAKE: begin
          if (port_b_shake) begin
            ctrl_b_level <= 1'b0;
          end else if (b_in_edge) begin
            ctrl_b_level <= 1'b1;
          end
        end
        CTL_PULSE: begin
          if (port_b_shake) begin
            ctrl_b_level <= 1'b0;
          end else if (phase_two_fall) begin
            ctrl_b_level <= 1'b1;
          end
        end
        CTL_MANUAL_LOW: ctrl_b_level <= 1'b0;
        CTL_MANUAL_HIGH: ctrl_b_level <= 1'b1;
        default: ctrl_b_level <= 1'b1;
      endcase
    end
  end

  assign ctrl_a_io_out = ctrl_a_level;
  assign ctrl_a_io_oe = mode_drives(a_io_mode);
  assign ctrl_b_io_out = serial_owns_ctrl_b ? serial_data_out
                                            : ctrl_b_level;
  assign ctrl_b_io_oe = serial_owns_ctrl_b ? serial_data_drive
                                           : mode_drives(b_io_mode);
  assign serial_clock_in = ctrl_b_in;
  assign serial_data_in = ctrl_b_io_in;

  // ----------------------------------------------------------------
  // Peripheral pins
  // ----------------------------------------------------------------
  assign port_a_pins_oe = port_a_direction;
  assign port_a_pins_out = port_a_output_value;
  // Timer ownership of bit 7 overrides the output register
  assign port_b_pins_oe = {port_b_direction[7] | timer_output_enable,
                           port_b_direction[6:0]};
  assign port_b_pins_out = {timer_output_enable ? timer_output_level
                                                : port_b_output_value[7],
                            port_b_output_value[6:0]};
  assign pulse_count_strobe = pulse_pin_q && !port_b_pins_in[6];

  // ----------------------------------------------------------------
  // Interrupt pin: open drain, only ever pulls low
  // ----------------------------------------------------------------
  assign irq_n_out = 1'b0;
  assign irq_n_oe = irq_active;

endmodule // dual_parallel_port

// [verification/dual_parallel_port_assertions.sv]
// Bus, pin and reset checks for the dual parallel port
module port_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic phase_two,
  input wire logic select_high_input,
  input wire logic select_low_input_n,
  input wire logic read_not_write,
  input wire logic host_data_bus_oe,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic [7:0] port_a_pins_oe,
  input wire logic [7:0] port_b_pins_in,
  input wire logic [7:0] port_b_pins_out,
  input wire logic [7:0] port_b_pins_oe,
  input wire logic port_a_capture_ready,
  input wire logic timer_output_enable,
  input wire logic timer_output_level,
  input wire logic pulse_count_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_bus_drive_window: assert property (host_data_bus_oe ==
    (phase_two && read_not_write && select_high_input
      && !select_low_input_n)) else $error("bus drive outside window");
  a_reset_all_clear: assert property ($rose(rst_n) |->
    port_a_pins_oe == 8'h00 && !irq_n_oe && port_a_capture_ready)
    else $error("state not clear after reset");
  a_irq_open_drain: assert property (irq_n_out == 1'b0)
    else $error("interrupt line driven high");
  // Pin directions move only after the phase-two commit, never mid-phase; port B bit 7 follows the timer
  a_dir_a_commit: assert property ($changed(port_a_pins_oe) |->
    !$past(phase_two) && $past(phase_two, 2))
    else $error("port A direction changed outside commit");
  a_dir_b_commit: assert property ($changed(port_b_pins_oe[6:0]) |->
    !$past(phase_two) && $past(phase_two, 2))
    else $error("port B direction changed outside commit");
  a_count_pulse_short: assert property (pulse_count_strobe |=>
    !pulse_count_strobe) else $error("count strobe longer than a cycle");
  a_count_on_fall: assert property ($fell(port_b_pins_in[6]) |->
    ##[0:2] pulse_count_strobe) else $error("count strobe missing");
  a_timer_owns_bit7: assert property (timer_output_enable [*2] ##0
    $stable(timer_output_level) |-> port_b_pins_oe[7]
      && port_b_pins_out[7] == timer_output_level)
    else $error("timer does not own port B bit 7");
  c_read: cover property (host_data_bus_oe);
  c_full: cover property ($fell(port_a_capture_ready));
  c_irq: cover property (!irq_n_oe ##1 irq_n_oe);
endmodule // port_checker

bind dual_parallel_port port_checker port_checker_inst (.*);

// [verification/periph_model.sv]
// Peripheral model: pin levels and data-taken answers
module periph_model #(
  parameter int DELAY = 6
) (
  input wire logic clk,
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic a2_out,
  input wire logic a2_oe,
  input wire logic b2_out,
  input wire logic b2_oe,
  input wire logic [7:0] drive_a,
  input wire logic [7:0] drive_b,
  input wire logic [7:0] load_b,
  input wire logic strobe_a,
  output logic [7:0] a_in,
  output logic [7:0] b_in,
  output logic a1,
  output logic b1,
  output logic a2_in,
  output logic b2_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_a = 0;
  int cnt_b = 0;
  logic ans_a = 1'b0;
  logic ans_b = 1'b0;
  // Heavy load on port B can hold a driven-high pin down
  assign a_in = (a_oe & a_out) | (~a_oe & drive_a);
  assign b_in = (b_oe & b_out & ~load_b) | (~b_oe & drive_b);
  assign a2_in = a2_oe ? a2_out : 1'b1;
  assign b2_in = b2_oe ? b2_out : 1'b1;
  assign a1 = ans_a | strobe_a;
  assign b1 = ans_b;
  // ----------------------------------------------------------------
  // Rising data-taken edge a while after data ready falls
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cnt_a <= (a2_oe && !a2_out) ? cnt_a + 1 : 0;
    cnt_b <= (b2_oe && !b2_out) ? cnt_b + 1 : 0;
    ans_a <= (cnt_a == DELAY) || (ans_a && cnt_a != 0);
    ans_b <= (cnt_b == DELAY) || (ans_b && cnt_b != 0);
  end
endmodule // periph_model

// [verification/tb_top.sv]
// Self-checking bench for the dual parallel port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import parallel_port_pkg::*;
  typedef struct {logic [7:0] dir, orv, pin, load;} row_t;
  logic clk = 1'b0, rst_n = 1'b0, phase_two = 1'b0;
  logic select_high_input = 1'b0, select_low_input_n = 1'b1;
  logic read_not_write = 1'b1, reg_sel_bit0 = 1'b0, reg_sel_bit1 = 1'b0;
  logic reg_sel_bit2 = 1'b0, reg_sel_bit3 = 1'b0;
  logic [7:0] host_data_bus_in, host_data_bus_out, wdata = 8'h00, rd;
  logic host_data_bus_oe, irq_n_out, irq_n_oe;
  logic [7:0] port_a_pins_in, port_a_pins_out, port_a_pins_oe;
  logic [7:0] port_b_pins_in, port_b_pins_out, port_b_pins_oe;
  logic ctrl_a_in, ctrl_a_io_in, ctrl_a_io_out, ctrl_a_io_oe;
  logic ctrl_b_in, ctrl_b_io_in, ctrl_b_io_out, ctrl_b_io_oe;
  logic port_a_capture_ready, pulse_count_strobe;
  logic timer_output_enable = 1'b0, timer_output_level = 1'b0;
  logic serial_owns_ctrl_b = 1'b0, serial_data_drive = 1'b0;
  logic serial_data_out = 1'b0, serial_clock_in, serial_data_in;
  logic [7:0] drive_a = 8'h00, drive_b = 8'h00, load_b = 8'h00, exp;
  logic strobe_a = 1'b0;
  int err_count = 0;
  int checks = 0;
  row_t rows[4] = '{'{8'h00, 8'hFF, 8'hA5, 8'h00},
    '{8'hFF, 8'h3C, 8'h00, 8'hFF}, '{8'h0F, 8'h96, 8'h5A, 8'h0F},
    '{8'hF0, 8'h00, 8'hFF, 8'h00}};
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : wdata;
  always #12.5 clk = ~clk;
  dual_parallel_port #(.CAPTURE_WORDS(8)) dual_parallel_port_inst (.*);
  periph_model periph_model_inst (.clk(clk), .a_out(port_a_pins_out),
    .a_oe(port_a_pins_oe), .b_out(port_b_pins_out), .b_oe(port_b_pins_oe),
    .a2_out(ctrl_a_io_out), .a2_oe(ctrl_a_io_oe), .b2_out(ctrl_b_io_out),
    .b2_oe(ctrl_b_io_oe), .drive_a(drive_a), .drive_b(drive_b),
    .load_b(load_b), .strobe_a(strobe_a), .a_in(port_a_pins_in),
    .b_in(port_b_pins_in), .a1(ctrl_a_in), .b1(ctrl_b_in),
    .a2_in(ctrl_a_io_in), .b2_in(ctrl_b_io_in));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, want);
    end
  endtask
  // Select drops with phase two; the sampled access still commits
  task automatic access(input logic [3:0] rs, input logic rw,
                        input logic [7:0] d, input logic sel);
    @(negedge clk);
    {reg_sel_bit3, reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = rs;
    read_not_write = rw;
    wdata = d;
    select_high_input = sel;
    select_low_input_n = 1'b0;
    phase_two = 1'b1;
    repeat (2) @(negedge clk);
    rd = host_data_bus_out;
    check(host_data_bus_oe, rw & sel);
    phase_two = 1'b0;
    select_high_input = 1'b0;
    select_low_input_n = 1'b1;
    @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] rs, input logic [7:0] d);
    access(rs, 1'b0, d, 1'b1);
  endtask
  task automatic rdchk(input logic [3:0] rs, input logic [7:0] want);
    access(rs, 1'b1, 8'h00, 1'b1);
    check(rd, want);
  endtask
  task automatic wait_high();
    for (int n = 0; n < 40 && !(ctrl_a_io_out && ctrl_b_io_out); n++)
      @(negedge clk);
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #100us;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check(port_a_pins_oe | port_b_pins_oe, 8'h00);
    check({irq_n_oe, ctrl_a_io_oe, port_a_capture_ready}, 3'b001);
    rdchk(REG_IRQ_ENABLE, 8'h80);
    rdchk(REG_AUX_CTRL, 8'h00);
    wr(4'h5, 8'hFF);
    rdchk(4'h5, 8'h00);
    foreach (rows[i]) begin
      drive_a = rows[i].pin;
      drive_b = rows[i].pin;
      load_b = rows[i].load;
      wr(REG_DIR_A, rows[i].dir);
      wr(REG_DIR_B, rows[i].dir);
      wr(REG_PORT_A_QUIET, rows[i].orv);
      wr(REG_PORT_B, rows[i].orv);
      exp = (rows[i].orv & rows[i].dir) | (rows[i].pin & ~rows[i].dir);
      check(port_a_pins_oe, rows[i].dir);
      check(port_a_pins_out, rows[i].orv);
      rdchk(REG_PORT_B, exp);
      rdchk(REG_PORT_A_QUIET, exp);
      rdchk(REG_DIR_B, rows[i].dir);
    end
    access(REG_DIR_A, 1'b0, 8'h00, 1'b0);
    rdchk(REG_DIR_A, 8'hF0);
    wr(REG_IRQ_ENABLE, 8'h92);
    wr(REG_PERIPH_CTRL, 8'h99);
    wr(REG_PORT_A_QUIET, 8'h11);
    check(ctrl_a_io_out, 1'b1);
    wr(REG_PORT_A, 8'h22);
    wr(REG_PORT_B, 8'h33);
    check({ctrl_a_io_out, ctrl_b_io_out}, 2'b00);
    wait_high();
    check({ctrl_a_io_out, ctrl_b_io_out, irq_n_oe}, 3'b111);
    rdchk(REG_IRQ_FLAGS, 8'h92);
    wr(REG_IRQ_FLAGS, 8'h12);
    check(irq_n_oe, 1'b0);
    rdchk(REG_PORT_A, 8'h2F);
    check(ctrl_a_io_out, 1'b0);
    wait_high();
    wr(REG_PERIPH_CTRL, 8'h0B);
    wr(REG_PORT_A, 8'h44);
    check(ctrl_a_io_out, 1'b0);
    rdchk(REG_PERIPH_CTRL, 8'h0B);
    check(ctrl_a_io_out, 1'b1);
    wait_high();
    wr(REG_PERIPH_CTRL, 8'h01);
    wr(REG_AUX_CTRL, 8'h01);
    wr(REG_DIR_A, 8'h00);
    // Nine captures into eight words: the last is dropped
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      drive_a = 8'hC0 | i[7:0];
      strobe_a = 1'b1;
      repeat (2) @(negedge clk);
      strobe_a = 1'b0;
      drive_a = 8'h55;
    end
    check(port_a_capture_ready, 1'b0);
    for (int i = 0; i < 8; i++)
      rdchk(REG_PORT_A, 8'hC0 | i[7:0]);
    check(port_a_capture_ready, 1'b1);
    timer_output_level = 1'b1;
    timer_output_enable = 1'b1;
    repeat (3) @(negedge clk);
    check({port_b_pins_oe[7], port_b_pins_out[7]}, 2'b11);
    timer_output_enable = 1'b0;
    // Serial owner pulls B2 low: no falling-edge flag may follow
    serial_owns_ctrl_b = 1'b1;
    serial_data_drive = 1'b1;
    @(negedge clk);
    check({ctrl_b_io_oe, ctrl_b_io_out, serial_data_in}, 3'b100);
    rdchk(REG_IRQ_FLAGS, 8'h00);
    serial_owns_ctrl_b = 1'b0;
    serial_data_drive = 1'b0;
    // Port B latch: B1 answer freezes the read until the flag clears
    wr(REG_AUX_CTRL, 8'h02);
    wr(REG_PERIPH_CTRL, 8'h90);
    wr(REG_PORT_B, 8'h00);
    wait_high();
    drive_b = 8'h3C;
    rdchk(REG_PORT_B, 8'h0F);
    rdchk(REG_PORT_B, 8'h0C);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    rdchk(REG_AUX_CTRL, 8'h00);
    rdchk(REG_DIR_B, 8'h00);
    tally_and_finish();
  end
endmodule // tb_top
